// ### rtl/pls_pkg.sv
// Shared constants and types for the PHY LED select and boot strap block
package pls_pkg;
	// Register byte offsets
	localparam logic [3:0] WAN_MISC_OFF = 4'h0;
	localparam logic [3:0] SW_CTRL0_OFF = 4'h4;
	localparam logic [3:0] FIBER_CFG_OFF = 4'h8;
	localparam logic [3:0] BOOT_STAT_OFF = 4'hC;
	localparam int ADDR_W = 4;

	// Field positions
	localparam int WAN_LED0_LSB = 0;
	localparam int WAN_LED1_LSB = 4;
	localparam int LAN_LED0_LSB = 25;
	localparam int LAN_LED1_LSB = 22;
	localparam int FX_WAN_BIT = 0;
	localparam int FX_LAN1_BIT = 1;
	localparam int STAT_RSVD_BIT = 2;
	localparam int STAT_WAN_SD_BIT = 3;
	localparam int STAT_LAN1_SD_BIT = 4;

	// Reset values and bus answers
	localparam logic [31:0] WAN_MISC_RST = 32'h0000_0000;
	localparam logic [31:0] SW_CTRL0_RST = 32'h0000_0000;
	localparam logic [1:0] FIBER_CFG_RST = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int NUM_LAN = 4;

	// LED select codes
	typedef enum logic [2:0] {
		LED_SPEED = 3'h0,
		LED_LINK = 3'h1,
		LED_DUPLEX = 3'h2,
		LED_COLL = 3'h3,
		LED_ACT = 3'h4,
		LED_FD_COLL = 3'h5,
		LED_LINK_ACT = 3'h6,
		LED_OFF = 3'h7
	} pls_led_sel_t;

	// Boot bank 0 width strap codes
	typedef enum logic [1:0] {
		BOOT_RSVD = 2'h0,
		BOOT_BYTE = 2'h1,
		BOOT_HALF = 2'h2,
		BOOT_WORD = 2'h3
	} pls_boot_width_t;

	// Per-port PHY indications
	typedef struct packed {
		logic speed_100;
		logic link;
		logic full_duplex;
		logic collision;
		logic activity;
	} pls_port_stat_t;
endpackage

// ### rtl/pls_led_sel.sv
// Per-port LED indication selector with registered LED outputs
`timescale 1ns/1ps
module pls_led_sel (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Indications and selects
	input wire pls_pkg::pls_port_stat_t stat_in,
	input wire pls_pkg::pls_led_sel_t sel0_in,
	input wire pls_pkg::pls_led_sel_t sel1_in,
	// LEDs, active high
	output logic led0_out,
	output logic led1_out
);
	logic led0_d;
	logic led1_d;
	logic led0_q;
	logic led1_q;

	function automatic logic pick(input pls_pkg::pls_port_stat_t s,
		input pls_pkg::pls_led_sel_t sel);
		logic r;
		r = 1'b0;
		unique case (sel)
			pls_pkg::LED_SPEED: r = s.speed_100;
			pls_pkg::LED_LINK: r = s.link;
			pls_pkg::LED_DUPLEX: r = s.full_duplex;
			pls_pkg::LED_COLL: r = s.collision;
			pls_pkg::LED_ACT: r = s.activity;
			pls_pkg::LED_FD_COLL: r = s.collision & s.full_duplex;
			// On with link, blinks off on activity
			pls_pkg::LED_LINK_ACT: r = s.link & ~s.activity;
			pls_pkg::LED_OFF: r = 1'b0;
		endcase
		return r;
	endfunction

	always_comb begin
		led0_d = pick(stat_in, sel0_in);
		led1_d = pick(stat_in, sel1_in);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			led0_q <= 1'b0;
			led1_q <= 1'b0;
		end else begin
			led0_q <= led0_d;
			led1_q <= led1_d;
		end
	end

	assign led0_out = led0_q;
	assign led1_out = led1_q;
endmodule // pls_led_sel

// ### rtl/pls_top.sv
// PHY LED select, boot width strap capture and fiber signal detect, AXI4-Lite registers
//
// Function
// - WAN LED pin 0 shows the indication chosen by WAN misc control bits [2:0].
// - WAN LED pin 1 shows the indication chosen by WAN misc control bits [6:4].
// - Each LAN port LED pin 0 shows the choice of switch control 0 bits [27:25].
// - Each LAN port LED pin 1 shows the choice of switch control 0 bits [24:22].
// - Select codes 0 speed, 1 link, 2 duplex, 3 coll, 4 activity, 5 FD coll, 6 link/act.
// - In reset both WAN LED pins are inputs, captured as the boot bank 0 width strap.
// - Strap decodes 01 byte, 10 half-word, 11 word; 00 is reserved and must not be strapped.
// - In WAN fiber mode the WAN signal-detect input serves as link detection.
// - In LAN1 fiber mode the LAN1 signal-detect input serves as link detection.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module pls_top (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic chip_reset_n_in,
	// AXI4-Lite write address and data
	input wire logic [pls_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// AXI4-Lite read
	input wire logic [pls_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// PHY indications
	input wire pls_pkg::pls_port_stat_t wan_stat_in,
	input wire pls_pkg::pls_port_stat_t [pls_pkg::NUM_LAN-1:0] lan_stat_in,
	// Fiber signal detect
	input wire logic wan_fiber_signal_detect_in,
	input wire logic lan1_fiber_signal_detect_in,
	// WAN LED pins shared with the boot width strap
	input wire logic wan_led_pin0_in,
	output logic wan_led_pin0_out,
	output logic wan_led_pin0_oe_n_out,
	input wire logic wan_led_pin1_in,
	output logic wan_led_pin1_out,
	output logic wan_led_pin1_oe_n_out,
	// LAN LED pins, bit 0 is port 1
	output logic [pls_pkg::NUM_LAN-1:0] lan_port_led_pin0_out,
	output logic [pls_pkg::NUM_LAN-1:0] lan_port_led_pin1_out,
	// Captured boot bank 0 width
	output pls_pkg::pls_boot_width_t boot_bank_width_strap_out
);
	////////////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops
	logic rst_meta_q;
	logic rst_n_q;
	always_ff @(posedge core_clk_in or negedge chip_reset_n_in) begin
		if (!chip_reset_n_in) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Boot width strap capture
	pls_pkg::pls_boot_width_t strap_d;
	pls_pkg::pls_boot_width_t strap_q;
	logic oe_n_d;
	logic oe_n_q;
	always_comb begin
		strap_d = strap_q;
		if (!rst_n_q) begin
			strap_d = pls_pkg::pls_boot_width_t'({wan_led_pin1_in, wan_led_pin0_in});
		end
		oe_n_d = ~rst_n_q;
	end
	// Sampled on every edge while reset is held, so no asynchronous reset here
	always_ff @(posedge core_clk_in) begin
		strap_q <= strap_d;
	end
	// Pins float as inputs from the moment reset goes low
	always_ff @(posedge core_clk_in or negedge chip_reset_n_in) begin
		if (!chip_reset_n_in) begin
			oe_n_q <= 1'b1;
		end else begin
			oe_n_q <= oe_n_d;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic [31:0] wan_misc_d;
	logic [31:0] wan_misc_q;
	logic [31:0] sw_ctrl0_d;
	logic [31:0] sw_ctrl0_q;
	logic [1:0] fiber_cfg_d;
	logic [1:0] fiber_cfg_q;
	logic aw_have_d;
	logic aw_have_q;
	logic w_have_d;
	logic w_have_q;
	logic [pls_pkg::ADDR_W-1:0] awaddr_d;
	logic [pls_pkg::ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_d;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_d;
	logic [3:0] wstrb_q;
	logic bvalid_d;
	logic bvalid_q;
	logic [1:0] bresp_d;
	logic [1:0] bresp_q;
	logic rvalid_d;
	logic rvalid_q;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic [1:0] rresp_d;
	logic [1:0] rresp_q;
	logic [31:0] boot_stat;
	logic [31:0] bmask;
	always_comb begin
		boot_stat = '0;
		boot_stat[1:0] = strap_q;
		boot_stat[pls_pkg::STAT_RSVD_BIT] = (strap_q == pls_pkg::BOOT_RSVD);
		boot_stat[pls_pkg::STAT_WAN_SD_BIT] = wan_fiber_signal_detect_in;
		boot_stat[pls_pkg::STAT_LAN1_SD_BIT] = lan1_fiber_signal_detect_in;
	end
	assign s_axi_awready_out = ~aw_have_q & ~bvalid_q;
	assign s_axi_wready_out = ~w_have_q & ~bvalid_q;
	assign s_axi_arready_out = ~rvalid_q;

	always_comb begin
		wan_misc_d = wan_misc_q;
		sw_ctrl0_d = sw_ctrl0_q;
		fiber_cfg_d = fiber_cfg_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		bmask = '0;
		for (int i = 0; i < 4; i++) begin
			bmask[i*8 +: 8] = {8{wstrb_q[i]}};
		end
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata_in;
			wstrb_d = s_axi_wstrb_in;
		end
		if (aw_have_q && w_have_q) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = pls_pkg::RESP_OKAY;
			unique case ({awaddr_q[pls_pkg::ADDR_W-1:2], 2'h0})
				pls_pkg::WAN_MISC_OFF:
					wan_misc_d = (wan_misc_q & ~bmask) | (wdata_q & bmask);
				pls_pkg::SW_CTRL0_OFF:
					sw_ctrl0_d = (sw_ctrl0_q & ~bmask) | (wdata_q & bmask);
				pls_pkg::FIBER_CFG_OFF: begin
					if (wstrb_q[0]) begin
						fiber_cfg_d = wdata_q[1:0];
					end
				end
				default: bresp_d = pls_pkg::RESP_SLVERR;
			endcase
		end
		if (bvalid_q && s_axi_bready_in) begin
			bvalid_d = 1'b0;
		end
		if (rvalid_q && s_axi_rready_in) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			rvalid_d = 1'b1;
			rresp_d = pls_pkg::RESP_OKAY;
			rdata_d = '0;
			unique case ({s_axi_araddr_in[pls_pkg::ADDR_W-1:2], 2'h0})
				pls_pkg::WAN_MISC_OFF: rdata_d = wan_misc_q;
				pls_pkg::SW_CTRL0_OFF: rdata_d = sw_ctrl0_q;
				pls_pkg::FIBER_CFG_OFF: rdata_d[1:0] = fiber_cfg_q;
				pls_pkg::BOOT_STAT_OFF: rdata_d = boot_stat;
				default: rresp_d = pls_pkg::RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wan_misc_q <= pls_pkg::WAN_MISC_RST;
			sw_ctrl0_q <= pls_pkg::SW_CTRL0_RST;
			fiber_cfg_q <= pls_pkg::FIBER_CFG_RST;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= pls_pkg::RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= pls_pkg::RESP_OKAY;
		end else begin
			wan_misc_q <= wan_misc_d;
			sw_ctrl0_q <= sw_ctrl0_d;
			fiber_cfg_q <= fiber_cfg_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rdata_out = rdata_q;
	assign s_axi_rresp_out = rresp_q;

	////////////////////////////////////////////////////////////////////////////////
	// Indication routing and LED selection; index 0 is WAN, 1..4 are LAN ports
	pls_pkg::pls_port_stat_t [pls_pkg::NUM_LAN:0] stat;
	pls_pkg::pls_led_sel_t [pls_pkg::NUM_LAN:0] sel0;
	pls_pkg::pls_led_sel_t [pls_pkg::NUM_LAN:0] sel1;
	logic [pls_pkg::NUM_LAN:0] led0;
	logic [pls_pkg::NUM_LAN:0] led1;

	always_comb begin
		stat[0] = wan_stat_in;
		if (fiber_cfg_q[pls_pkg::FX_WAN_BIT]) begin
			stat[0].link = wan_fiber_signal_detect_in;
		end
		stat[pls_pkg::NUM_LAN:1] = lan_stat_in;
		if (fiber_cfg_q[pls_pkg::FX_LAN1_BIT]) begin
			stat[1].link = lan1_fiber_signal_detect_in;
		end
	end

	genvar p;
	generate
		for (p = 0; p <= pls_pkg::NUM_LAN; p++) begin : g_port
			if (p == 0) begin : g_wan
				assign sel0[p] = pls_pkg::pls_led_sel_t'(
					wan_misc_q[pls_pkg::WAN_LED0_LSB +: 3]);
				assign sel1[p] = pls_pkg::pls_led_sel_t'(
					wan_misc_q[pls_pkg::WAN_LED1_LSB +: 3]);
			end else begin : g_lan
				assign sel0[p] = pls_pkg::pls_led_sel_t'(
					sw_ctrl0_q[pls_pkg::LAN_LED0_LSB +: 3]);
				assign sel1[p] = pls_pkg::pls_led_sel_t'(
					sw_ctrl0_q[pls_pkg::LAN_LED1_LSB +: 3]);
			end
			pls_led_sel u_sel (
				.clk_in(core_clk_in),
				.rst_n_in(rst_n_q),
				.stat_in(stat[p]),
				.sel0_in(sel0[p]),
				.sel1_in(sel1[p]),
				.led0_out(led0[p]),
				.led1_out(led1[p])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Pin outputs
	assign wan_led_pin0_out = led0[0];
	assign wan_led_pin1_out = led1[0];
	assign wan_led_pin0_oe_n_out = oe_n_q;
	assign wan_led_pin1_oe_n_out = oe_n_q;
	assign lan_port_led_pin0_out = led0[pls_pkg::NUM_LAN:1];
	assign lan_port_led_pin1_out = led1[pls_pkg::NUM_LAN:1];
	assign boot_bank_width_strap_out = strap_q;
endmodule // pls_top

// ### verification/pls_sva.sv
// Port assertions for the LED select and boot strap block
`timescale 1ns/1ps
module pls_sva (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic chip_reset_n_in,
	// AXI4-Lite handshakes
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	// WAN pins and strap
	input wire logic wan_led_pin0_in,
	input wire logic wan_led_pin1_in,
	input wire logic wan_led_pin0_out,
	input wire logic wan_led_pin0_oe_n_out,
	input wire logic wan_led_pin1_oe_n_out,
	input wire pls_pkg::pls_boot_width_t boot_bank_width_strap_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!chip_reset_n_in);
	////////////////////////////////////////
	a_pins_released: assert property (disable iff (1'b0)
		!chip_reset_n_in |-> wan_led_pin0_oe_n_out && wan_led_pin1_oe_n_out && !wan_led_pin0_out)
		else $error("WAN pins driven in reset");
	a_strap_follow: assert property (disable iff (1'b0)
		$past(!chip_reset_n_in) && !chip_reset_n_in |->
		boot_bank_width_strap_out == $past({wan_led_pin1_in, wan_led_pin0_in}))
		else $error("Strap not captured");
	a_strap_frozen: assert property (
		chip_reset_n_in && $past(chip_reset_n_in, 3) |-> $stable(boot_bank_width_strap_out))
		else $error("Strap changed after reset");
	a_pins_driven: assert property (
		chip_reset_n_in && $past(chip_reset_n_in, 4) |-> !wan_led_pin0_oe_n_out && !wan_led_pin1_oe_n_out)
		else $error("WAN pins not driven");
	a_b_stands: assert property (
		s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("Write response dropped");
	a_b_blocks: assert property (
		s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("Write taken during response");
	a_b_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
		s_axi_wready_out && !s_axi_bvalid_out |-> ##[1:2] s_axi_bvalid_out)
		else $error("Write response missing");
	a_r_answer: assert property (
		s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("Read response missing");
	a_r_stands: assert property (
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("Read data dropped");
endmodule // pls_sva
////////////////////////////////////////
bind pls_top pls_sva i_pls_sva (.*);

// ### verification/pls_partner.sv
// Strap resistors, LED wiring and fiber transceivers
`timescale 1ns/1ps
module pls_partner (
	// Drive from the block
	input wire logic oe0_n_in,
	input wire logic oe1_n_in,
	input wire logic led0_in,
	input wire logic led1_in,
	// Bench controls
	input wire logic [1:0] strap_in,
	input wire logic wan_sd_in,
	input wire logic lan_sd_in,
	// Levels seen by the block
	output logic pin0_out,
	output logic pin1_out,
	output logic wan_sd_out,
	output logic lan_sd_out
);
	// Resistor level wins only while the pin is released
	assign pin0_out = oe0_n_in ? strap_in[0] : led0_in;
	assign pin1_out = oe1_n_in ? strap_in[1] : led1_in;
	assign wan_sd_out = wan_sd_in;
	assign lan_sd_out = lan_sd_in;
endmodule // pls_partner

// ### verification/testbench.sv
// Self-checking bench for the LED select and boot strap block
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b1;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic wan_sd = 1'b0, lan_sd = 1'b0;
	logic [1:0] strap = 2'h1;
	pls_pkg::pls_port_stat_t wan_st = '0;
	pls_pkg::pls_port_stat_t [3:0] lan_st = '0;
	wire awready, wready, bvalid, arready, rvalid, p0, p1, o0, o1, oe0_n, oe1_n, wsd, lsd;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [3:0] l0, l1;
	pls_pkg::pls_boot_width_t bw;
	int err_count = 0, num_checks = 0, seed = 45078;
	always #50 clk = ~clk;
	pls_top i_pls_top (.core_clk_in(clk), .chip_reset_n_in(rst_n), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .wan_stat_in(wan_st), .lan_stat_in(lan_st),
		.wan_fiber_signal_detect_in(wsd), .lan1_fiber_signal_detect_in(lsd),
		.wan_led_pin0_in(p0), .wan_led_pin0_out(o0), .wan_led_pin0_oe_n_out(oe0_n),
		.wan_led_pin1_in(p1), .wan_led_pin1_out(o1), .wan_led_pin1_oe_n_out(oe1_n),
		.lan_port_led_pin0_out(l0), .lan_port_led_pin1_out(l1), .boot_bank_width_strap_out(bw));
	pls_partner i_pls_partner (.oe0_n_in(oe0_n), .oe1_n_in(oe1_n), .led0_in(o0), .led1_in(o1),
		.strap_in(strap), .wan_sd_in(wan_sd), .lan_sd_in(lan_sd), .pin0_out(p0), .pin1_out(p1),
		.wan_sd_out(wsd), .lan_sd_out(lsd));
	////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		if (err_count == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		logic [1:0] r;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge clk);
			aw = awvalid & awready;
			w = wvalid & wready;
			b = bvalid;
			r = bresp;
			@(posedge clk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk(32'(r), 32'(er));
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, v;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		v = 1'b0;
		while (!v) begin
			@(negedge clk);
			ar = arvalid & arready;
			v = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ar) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	function automatic logic led(pls_pkg::pls_port_stat_t s, logic [2:0] c, logic fx, logic sd);
		logic l;
		l = fx ? sd : s.link;
		case (c)
			3'h0: return s.speed_100;
			3'h1: return l;
			3'h2: return s.full_duplex;
			3'h3: return s.collision;
			3'h4: return s.activity;
			3'h5: return s.collision & s.full_duplex;
			3'h6: return l & !s.activity;
			default: return 1'b0;
		endcase
	endfunction
	task automatic led_round(input int i);
		logic [31:0] wm, sc, d;
		logic [2:0] c0, c1, c2, c3;
		logic [1:0] fx, r;
		c0 = 3'(i);
		c1 = 3'(i + 3);
		c2 = 3'(i + 5);
		c3 = 3'(i + 6);
		wm = $random(seed);
		wm[2:0] = c0;
		wm[6:4] = c1;
		sc = $random(seed);
		sc[27:25] = c2;
		sc[24:22] = c3;
		fx = 2'($random(seed));
		wr(pls_pkg::WAN_MISC_OFF, wm, pls_pkg::RESP_OKAY);
		wr(pls_pkg::SW_CTRL0_OFF, sc, pls_pkg::RESP_OKAY);
		wr(pls_pkg::FIBER_CFG_OFF, 32'(fx), pls_pkg::RESP_OKAY);
		rd(pls_pkg::WAN_MISC_OFF, d, r);
		chk(d, wm);
		rd(pls_pkg::SW_CTRL0_OFF, d, r);
		chk(d, sc);
		repeat (3) begin
			@(posedge clk);
			wan_st <= 5'($random(seed));
			lan_st <= 20'($random(seed));
			wan_sd <= 1'($random(seed));
			lan_sd <= 1'($random(seed));
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk(32'(o0), 32'(led(wan_st, c0, fx[0], wan_sd)));
			chk(32'(o1), 32'(led(wan_st, c1, fx[0], wan_sd)));
			for (int p = 0; p < 4; p++) begin
				chk(32'(l0[p]), 32'(led(lan_st[p], c2, fx[1] && p == 0, lan_sd)));
				chk(32'(l1[p]), 32'(led(lan_st[p], c3, fx[1] && p == 0, lan_sd)));
			end
		end
		rd(pls_pkg::BOOT_STAT_OFF, d, r);
		chk(32'(d[4:3]), 32'({lan_sd, wan_sd}));
	endtask
	////////////////////////////////////////
	initial begin
		#3000000;
		err_count++;
		conclude();
	end
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		// Reset edge at time zero so every flop with an asynchronous reset starts out known
		rst_n <= 1'b0;
		for (int s = 1; s < 4; s++) begin
			@(posedge clk);
			strap <= 2'(s);
			rst_n <= 1'b0;
			repeat (256) @(posedge clk);
			rst_n <= 1'b1;
			repeat (4) @(posedge clk);
			strap <= ~2'(s);
			chk(32'(bw), 32'(s));
			rd(pls_pkg::WAN_MISC_OFF, d, r);
			chk(d, pls_pkg::WAN_MISC_RST);
			rd(pls_pkg::SW_CTRL0_OFF, d, r);
			chk(d, pls_pkg::SW_CTRL0_RST);
			rd(pls_pkg::FIBER_CFG_OFF, d, r);
			chk(32'(d[1:0]), 32'(pls_pkg::FIBER_CFG_RST));
			rd(pls_pkg::BOOT_STAT_OFF, d, r);
			chk(32'(d[2:0]), 32'(s));
			wr(pls_pkg::BOOT_STAT_OFF, 32'hFFFF_FFFF, pls_pkg::RESP_SLVERR);
			// Low address bits are ignored: byte 2 reads the WAN misc word
			rd(4'h2, d, r);
			chk(32'(r), 32'(pls_pkg::RESP_OKAY));
			chk(d, pls_pkg::WAN_MISC_RST);
			for (int i = 0; i < 8; i++) led_round(i);
			chk(32'(bw), 32'(s));
		end
		conclude();
	end
endmodule // testbench
